// ==== rtl/sab_pkg.sv ====
// Shared constants and types for the converter control and bus interface.
package sab_pkg;

    localparam int RES_W = 12;
    localparam int DW    = 16;
    localparam int AW    = 3;
    localparam int NEV   = 2;

    localparam int CLK_MHZ  = 100;
    localparam int STEP_NS  = 1000;
    localparam int STEP_CYC = (STEP_NS * CLK_MHZ) / 1000;

    localparam logic [6:0] STEP_LAST = 7'(STEP_CYC - 1);

    localparam int FULL_BITS  = 12;
    localparam int SHORT_BITS = 8;
    localparam int FULL_CYC   = FULL_BITS * STEP_CYC;
    localparam int SHORT_CYC  = SHORT_BITS * STEP_CYC;

    localparam logic [3:0] MSB_POS        = 4'hB;
    localparam logic [3:0] FULL_LAST_POS  = 4'h0;
    localparam logic [3:0] SHORT_LAST_POS = 4'h4;

    localparam logic [AW-1:0] ADDR_CTRL    = 3'h0;
    localparam logic [AW-1:0] ADDR_STATUS  = 3'h1;
    localparam logic [AW-1:0] ADDR_IRQ_EN  = 3'h2;
    localparam logic [AW-1:0] ADDR_IRQ_CLR = 3'h3;
    localparam logic [AW-1:0] ADDR_RESULT  = 3'h4;

    localparam int CTRL_STANDALONE_BIT = 0;
    localparam int EV_DONE             = 0;
    localparam int EV_IGNORED          = 1;

    localparam logic             CTRL_RST   = 1'b0;
    localparam logic [NEV-1:0]   IRQ_RST    = 2'h0;
    localparam logic [RES_W-1:0] RESULT_RST = 12'h000;
    localparam logic [2:0]       OE_OFF     = 3'h7;

    // Synchronised pin vector layout
    localparam int PIN_CE   = 0;
    localparam int PIN_CSN  = 1;
    localparam int PIN_RC   = 2;
    localparam int PIN_A0   = 3;
    localparam int PIN_WORD = 4;
    localparam int PIN_COMP = 5;
    localparam int PIN_W    = 6;

    typedef enum logic [0:0] {
        SAB_IDLE = 1'b0,
        SAB_CONV = 1'b1
    } sab_fsm_t;

endpackage

// ==== rtl/sab_sync.sv ====
// Two-flop synchroniser bank for asynchronous pin inputs.
`timescale 1ns/10ps
`default_nettype none
module sab_sync #(
    parameter int W = 6
) (
    input  wire logic         mclk_i,  // System clock
    input  wire logic         srst_i,  // Synchronous reset
    input  wire logic [W-1:0] async_i, // Raw pin levels
    output logic      [W-1:0] sync_o   // Levels in clock domain
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sab_sync_st_t;

    sab_sync_st_t st;
    sab_sync_st_t next_st;

    always_comb
    begin
        next_st    = st;
        next_st.s1 = async_i;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign sync_o = st.s2;
endmodule
`default_nettype wire

// ==== rtl/sab_adc_ctrl.sv ====
// Successive-approximation converter control, output buffers and registers.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module sab_adc_ctrl
    import sab_pkg::*;
(
    input  wire logic                     mclk_i,                   // 100 MHz clock
    input  wire logic                     srst_i,                   // Sync reset
    input  wire logic                     chip_en_i,                // Chip enable pin
    input  wire logic                     chip_sel_n_i,             // Chip select pin
    input  wire logic                     read_convert_i,           // Read/convert pin
    input  wire logic                     byte_addr_short_cycle_i,  // Byte addr pin
    input  wire logic                     word_fmt_i,               // 1 = word
    input  wire logic                     comp_i,                   // DAC sum above input
    output logic      [sab_pkg::RES_W-1:0] dac_code_o,              // Trial code
    output logic                          conversion_busy_o,        // Busy status pin
    output logic      [3:0]               data_upper_nibble_o,      // Bits 11..8
    output logic      [3:0]               data_middle_nibble_o,     // Bits 7..4
    output logic      [3:0]               data_low_nibble_o,        // Bits 3..0
    output logic                          data_upper_oe_n_o,        // Upper drive, low
    output logic                          data_middle_oe_n_o,       // Middle drive, low
    output logic                          data_low_oe_n_o,          // Low drive, low
    input  wire logic [sab_pkg::AW-1:0]   reg_addr_i,               // Register index
    input  wire logic [sab_pkg::DW-1:0]   reg_wdata_i,              // Write data
    input  wire logic                     reg_we_i,                 // Write strobe
    input  wire logic                     reg_re_i,                 // Read strobe
    output logic      [sab_pkg::DW-1:0]   reg_rdata_o,              // Read data
    output logic                          irq_o                     // Interrupt level
);
    import sab_pkg::*;

    typedef struct packed {
        sab_fsm_t         fsm;
        logic             standalone;
        logic [NEV-1:0]   irq_en;
        logic [NEV-1:0]   irq_sts;
        logic             short_cyc;
        logic [RES_W-1:0] sar;
        logic [RES_W-1:0] result;
        logic [3:0]       bit_pos;
        logic [6:0]       div_cnt;
        logic             rc_prev;
        logic             cmd_prev;
        logic [DW-1:0]    rdata;
        logic [3:0]       up;
        logic [3:0]       mid;
        logic [3:0]       lo;
        logic [2:0]       oe_n;
    } sab_state_t;

    sab_state_t st;
    sab_state_t next_st;

    logic [PIN_W-1:0] pins_s;
    logic             ce_s;
    logic             csn_s;
    logic             rc_s;
    logic             a0_s;
    logic             word_s;
    logic             comp_s;
    logic             sel;
    logic             cmd_conv;
    logic             start_req;
    logic             rd_q;
    logic             step_tick;
    logic [NEV-1:0]   ev_set;

    function automatic logic [RES_W-1:0] bit_mask(input logic [3:0] pos);
        bit_mask = 12'h001 << pos;
    endfunction

    sab_sync #(
        .W (PIN_W)
    ) u_sync (
        .mclk_i  (mclk_i),
        .srst_i  (srst_i),
        .async_i ({comp_i, word_fmt_i, byte_addr_short_cycle_i,
                   read_convert_i, chip_sel_n_i, chip_en_i}),
        .sync_o  (pins_s)
    );

    assign ce_s   = pins_s[PIN_CE];
    assign csn_s  = pins_s[PIN_CSN];
    assign rc_s   = pins_s[PIN_RC];
    assign a0_s   = pins_s[PIN_A0];
    assign word_s = pins_s[PIN_WORD];
    assign comp_s = pins_s[PIN_COMP];

    assign sel       = ce_s && !csn_s;
    assign cmd_conv  = sel && !rc_s;
    // Standalone starts on the falling edge, full control on command entry
    assign start_req = st.standalone ? (sel && st.rc_prev && !rc_s)
                                     : (cmd_conv && !st.cmd_prev);
    assign rd_q      = sel && rc_s && (st.fsm == SAB_IDLE);
    assign step_tick = (st.fsm == SAB_CONV) && (st.div_cnt == STEP_LAST);

    always_comb
    begin
        next_st          = st;
        ev_set           = '0;
        next_st.rc_prev  = rc_s;
        next_st.cmd_prev = cmd_conv;

        unique case (st.fsm)
            SAB_IDLE:
            begin
                if (start_req)
                begin
                    // Short cycle choice is latched at start
                    next_st.fsm       = SAB_CONV;
                    next_st.short_cyc = a0_s;
                    next_st.sar       = bit_mask(MSB_POS);
                    next_st.bit_pos   = MSB_POS;
                    next_st.div_cnt   = 7'h00;
                end
            end
            SAB_CONV:
            begin
                if (start_req)
                begin
                    ev_set[EV_IGNORED] = 1'b1;
                end
                next_st.div_cnt = st.div_cnt + 7'h01;
                if (step_tick)
                begin
                    next_st.div_cnt = 7'h00;
                    if (comp_s)
                    begin
                        next_st.sar = st.sar & ~bit_mask(st.bit_pos);
                    end
                    if (st.bit_pos == (st.short_cyc ? SHORT_LAST_POS : FULL_LAST_POS))
                    begin
                        // MSB-first code, unused LSBs zero: left-justified
                        next_st.result    = next_st.sar;
                        next_st.fsm       = SAB_IDLE;
                        ev_set[EV_DONE]   = 1'b1;
                    end
                    else
                    begin
                        next_st.bit_pos = st.bit_pos - 4'h1;
                        next_st.sar     = next_st.sar | bit_mask(st.bit_pos - 4'h1);
                    end
                end
            end
        endcase

        // Output buffers; registered so the pins never glitch
        next_st.oe_n = OE_OFF;
        next_st.up   = 4'h0;
        next_st.mid  = 4'h0;
        next_st.lo   = 4'h0;
        if (rd_q)
        begin
            if (word_s)
            begin
                next_st.oe_n = 3'h0;
                next_st.up   = st.result[11:8];
                next_st.mid  = st.result[7:4];
                next_st.lo   = st.result[3:0];
            end
            else if (!a0_s)
            begin
                next_st.oe_n = 3'h1;
                next_st.up   = st.result[11:8];
                next_st.mid  = st.result[7:4];
            end
            else
            begin
                next_st.oe_n = 3'h4;
                next_st.mid  = 4'h0;
                next_st.lo   = st.result[3:0];
            end
        end

        // Register writes
        if (reg_we_i)
        begin
            unique case (reg_addr_i)
                ADDR_CTRL:    next_st.standalone = reg_wdata_i[CTRL_STANDALONE_BIT];
                ADDR_IRQ_EN:  next_st.irq_en = reg_wdata_i[NEV-1:0];
                ADDR_IRQ_CLR: next_st.irq_sts = st.irq_sts & ~reg_wdata_i[NEV-1:0];
                default:      next_st.irq_sts = next_st.irq_sts;
            endcase
        end
        // Hardware set wins over a same-cycle clear
        next_st.irq_sts = next_st.irq_sts | ev_set;

        next_st.rdata = '0;
        if (reg_re_i)
        begin
            unique case (reg_addr_i)
                ADDR_CTRL:   next_st.rdata = {15'h0000, st.standalone};
                ADDR_STATUS: next_st.rdata = {14'h0000, st.irq_sts};
                ADDR_IRQ_EN: next_st.rdata = {14'h0000, st.irq_en};
                ADDR_RESULT: next_st.rdata = {(st.fsm == SAB_CONV), st.short_cyc,
                                              2'h0, st.result};
                default:     next_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            st            <= '0;
            st.fsm        <= SAB_IDLE;
            st.standalone <= CTRL_RST;
            st.irq_en     <= IRQ_RST;
            st.irq_sts    <= IRQ_RST;
            st.result     <= RESULT_RST;
            st.oe_n       <= OE_OFF;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign dac_code_o           = st.sar;
    assign conversion_busy_o    = (st.fsm == SAB_CONV);
    assign data_upper_nibble_o  = st.up;
    assign data_middle_nibble_o = st.mid;
    assign data_low_nibble_o    = st.lo;
    assign data_upper_oe_n_o    = st.oe_n[2];
    assign data_middle_oe_n_o   = st.oe_n[1];
    assign data_low_oe_n_o      = st.oe_n[0];
    assign reg_rdata_o          = st.rdata;
    assign irq_o                = |(st.irq_sts & st.irq_en);

    // Assertion helper: cycles spent in the current conversion
    logic [15:0] busy_cnt;

    always_ff @(posedge mclk_i)
    begin
        if (srst_i || (st.fsm == SAB_IDLE))
        begin
            busy_cnt <= 16'h0000;
        end
        else
        begin
            busy_cnt <= busy_cnt + 16'h0001;
        end
    end

    property p_full_len;
        @(posedge mclk_i) disable iff (srst_i)
        ($fell(conversion_busy_o) && !st.short_cyc) |-> (busy_cnt == 16'(FULL_CYC));
    endproperty
    a_full_len: assert property (p_full_len) else $error("full conversion length wrong");

    property p_short_len;
        @(posedge mclk_i) disable iff (srst_i)
        ($fell(conversion_busy_o) && st.short_cyc)
            |-> (busy_cnt == 16'(SHORT_CYC)) && (st.result[3:0] == 4'h0);
    endproperty
    a_short_len: assert property (p_short_len) else $error("short conversion wrong");

    property p_start_busy;
        @(posedge mclk_i) disable iff (srst_i)
        (start_req && !conversion_busy_o)
            |=> conversion_busy_o && (dac_code_o == 12'h800) && (st.short_cyc == $past(a0_s));
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start not taken");

    property p_no_sel;
        @(posedge mclk_i) disable iff (srst_i)
        (!conversion_busy_o && !sel) |=> !conversion_busy_o;
    endproperty
    a_no_sel: assert property (p_no_sel) else $error("start without enable/select");

    property p_ignore;
        @(posedge mclk_i) disable iff (srst_i)
        (conversion_busy_o && start_req && !step_tick)
            |=> st.irq_sts[EV_IGNORED] && ($stable(st.bit_pos));
    endproperty
    a_ignore: assert property (p_ignore) else $error("restart during conversion");

    property p_float;
        @(posedge mclk_i) disable iff (srst_i)
        !rd_q |=> (st.oe_n == OE_OFF);
    endproperty
    a_float: assert property (p_float) else $error("drive without qualified read");

    property p_busy_float;
        @(posedge mclk_i) disable iff (srst_i)
        conversion_busy_o[*2] |-> (st.oe_n == OE_OFF);
    endproperty
    a_busy_float: assert property (p_busy_float) else $error("drive while busy");

    property p_word;
        @(posedge mclk_i) disable iff (srst_i)
        (rd_q && word_s) |=> (st.oe_n == 3'h0) && (data_upper_nibble_o == st.result[11:8])
                             && (data_middle_nibble_o == st.result[7:4]);
    endproperty
    a_word: assert property (p_word) else $error("word format read wrong");

    property p_byte_hi;
        @(posedge mclk_i) disable iff (srst_i)
        (rd_q && !word_s && !a0_s) |=> (st.oe_n == 3'h1)
                                       && (data_upper_nibble_o == st.result[11:8]);
    endproperty
    a_byte_hi: assert property (p_byte_hi) else $error("high byte read wrong");

    property p_byte_lo;
        @(posedge mclk_i) disable iff (srst_i)
        (rd_q && !word_s && a0_s) |=> (st.oe_n == 3'h4) && (data_middle_nibble_o == 4'h0)
                                      && (data_low_nibble_o == st.result[3:0]);
    endproperty
    a_byte_lo: assert property (p_byte_lo) else $error("low byte read wrong");

    property p_irq;
        @(posedge mclk_i) disable iff (srst_i)
        $rose(st.irq_sts[EV_DONE]) |-> $fell(conversion_busy_o);
    endproperty
    a_irq: assert property (p_irq) else $error("done flag without completion");

    c_full:  cover property (@(posedge mclk_i) $fell(conversion_busy_o) && !st.short_cyc);
    c_short: cover property (@(posedge mclk_i) $fell(conversion_busy_o) && st.short_cyc);
    c_read:  cover property (@(posedge mclk_i) rd_q && !word_s && a0_s);
    c_ign:   cover property (@(posedge mclk_i) conversion_busy_o && start_req);
endmodule
`default_nettype wire

// ==== testbench/sab_comp_model.sv ====
// Comparator model: analog input level compared with the converter's trial code.
`timescale 1ns/10ps
`default_nettype none
module sab_comp_model
    import sab_pkg::*;
(
    input  wire logic [sab_pkg::RES_W-1:0] dac_code_i, // Trial code
    input  wire logic [sab_pkg::RES_W-1:0] level_i,    // Input level as a code
    output logic                           comp_o      // High when trial sum above input
);
    import sab_pkg::*;
    // Equal sum keeps the bit on, so a full conversion lands on the level itself
    assign comp_o = (dac_code_i > level_i);
endmodule
`default_nettype wire

// ==== testbench/test_sar_adc_bus_interface.sv ====
// Self-checking bench for the converter control and bus interface.
`timescale 1ns/10ps
`default_nettype none
module test_sar_adc_bus_interface;
    import sab_pkg::*;
    logic             mclk_i = 1'b0;
    logic             srst   = 1'b1;
    logic             ce     = 1'b0;
    logic             cs_n   = 1'b1;
    logic             rc     = 1'b1;
    logic             a0     = 1'b0;
    logic             wfmt   = 1'b1;
    logic             comp;
    logic [RES_W-1:0] dac;
    logic [RES_W-1:0] level  = 12'h000;
    logic             busy;
    logic [3:0]       up;
    logic [3:0]       mid;
    logic [3:0]       low;
    logic             up_oe_n;
    logic             mid_oe_n;
    logic             low_oe_n;
    logic [AW-1:0]    addr   = 3'h0;
    logic [DW-1:0]    wdata  = 16'h0000;
    logic             we     = 1'b0;
    logic             re     = 1'b0;
    logic [DW-1:0]    rdata;
    logic             irq;
    int               n_mismatch  = 0;
    int               comparisons = 0;
    int               exp_q[$];
    int               res;
    logic [DW-1:0]    rd;
    logic [11:0]      vins[8] = '{12'hFFF, 12'h800, 12'h7FF, 12'h000, 12'h5A3, 0, 0, 0};

    always #5 mclk_i = ~mclk_i;

    sab_adc_ctrl dut_u (
        .mclk_i(mclk_i), .srst_i(srst), .chip_en_i(ce), .chip_sel_n_i(cs_n),
        .read_convert_i(rc), .byte_addr_short_cycle_i(a0), .word_fmt_i(wfmt),
        .comp_i(comp), .dac_code_o(dac), .conversion_busy_o(busy),
        .data_upper_nibble_o(up), .data_middle_nibble_o(mid), .data_low_nibble_o(low),
        .data_upper_oe_n_o(up_oe_n), .data_middle_oe_n_o(mid_oe_n),
        .data_low_oe_n_o(low_oe_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .irq_o(irq)
    );

    sab_comp_model comp_u (.dac_code_i(dac), .level_i(level), .comp_o(comp));

    task automatic finish_test;
        if (n_mismatch == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge mclk_i);
        addr  <= a;
        wdata <= d;
        we    <= 1'b1;
        @(posedge mclk_i);
        we    <= 1'b0;
    endtask

    task automatic chk_rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        @(posedge mclk_i);
        addr <= a;
        re   <= 1'b1;
        @(posedge mclk_i);
        re   <= 1'b0;
        @(negedge mclk_i);
        chk("register", exp, rdata);
    endtask

    // Integer successive approximation, greedy from the MSB
    function automatic int model_sar(input int lvl, input int short_c);
        int code;
        code = 0;
        for (int b = 11; b >= (short_c ? 4 : 0); b--)
            if ((code | (1 << b)) <= lvl)
                code = code | (1 << b);
        return code;
    endfunction

    task automatic settle(input int n);
        repeat (n) @(negedge mclk_i);
    endtask

    task automatic convert(input logic sh, input logic alone, input logic poke,
                           input logic [11:0] lv);
        int n;
        int exp;
        reg_wr(ADDR_CTRL, {15'h0, alone});
        @(posedge mclk_i);
        level <= lv;
        a0    <= sh;
        ce    <= 1'b1;
        cs_n  <= 1'b0;
        rc    <= alone;
        if (alone)
        begin
            repeat (4) @(posedge mclk_i);
            rc <= 1'b0;
        end
        n = 0;
        @(negedge mclk_i);
        while (busy !== 1'b1 && n < 8)
        begin
            @(negedge mclk_i);
            n++;
        end
        chk("busy rise", 16'h1, 16'(busy));
        chk("first trial", 16'h800, 16'(dac));
        n = 0;
        while (busy === 1'b1 && n < 1300)
        begin
            @(posedge mclk_i);
            if (poke && n == 20)
                ce <= 1'b0;
            if (poke && n == 30)
                ce <= 1'b1;
            if (poke && n == 40)
                rc <= 1'b1;
            @(negedge mclk_i);
            if (poke && n == 50)
                chk("oe_n busy", 16'h7, {13'h0, up_oe_n, mid_oe_n, low_oe_n});
            n++;
        end
        chk("busy cycles", 16'(sh ? SHORT_CYC : FULL_CYC), 16'(n));
        @(posedge mclk_i);
        ce <= 1'b0;
        rc <= 1'b1;
        exp = model_sar(lv, sh);
        exp_q.push_back(exp);
        chk_rd(ADDR_RESULT, 16'((int'(sh) << 14) | exp));
        chk_rd(ADDR_STATUS, poke ? 16'h3 : 16'h1);
        if (poke)
        begin
            chk("irq masked", 16'h0, 16'(irq));
            reg_wr(ADDR_IRQ_EN, 16'h0001);
            settle(2);
            chk("irq raised", 16'h1, 16'(irq));
        end
        reg_wr(ADDR_IRQ_CLR, 16'h0003);
        settle(2);
        chk("irq cleared", 16'h0, 16'(irq));
        chk_rd(ADDR_STATUS, 16'h0);
    endtask

    task automatic rd_pins(input logic word, input logic a, input logic [11:0] r);
        @(posedge mclk_i);
        ce   <= 1'b1;
        cs_n <= 1'b0;
        rc   <= 1'b1;
        a0   <= a;
        wfmt <= word;
        settle(4);
        if (word)
        begin
            chk("oe_n word", 16'h0, {13'h0, up_oe_n, mid_oe_n, low_oe_n});
            chk("word data", 16'(r), {4'h0, up, mid, low});
        end
        else if (!a)
        begin
            chk("oe_n byte hi", 16'h1, {13'h0, up_oe_n, mid_oe_n, low_oe_n});
            chk("byte hi data", 16'(r[11:4]), {8'h0, up, mid});
        end
        else
        begin
            chk("oe_n byte lo", 16'h4, {13'h0, up_oe_n, mid_oe_n, low_oe_n});
            chk("byte lo data", 16'(r[3:0]), {8'h0, mid, low});
        end
        @(posedge mclk_i);
        ce <= 1'b0;
        settle(4);
        chk("oe_n idle", 16'h7, {13'h0, up_oe_n, mid_oe_n, low_oe_n});
    endtask

    initial
    begin
        repeat (40000) @(posedge mclk_i);
        n_mismatch++;
        finish_test();
    end

    initial
    begin
        void'($urandom(32'hA9B6));
        for (int i = 5; i < 8; i++)
            vins[i] = 12'($urandom);
        repeat (12) @(posedge mclk_i);
        srst <= 1'b0;
        repeat (3) @(posedge mclk_i);
        chk_rd(ADDR_CTRL, 16'h0000);
        chk_rd(ADDR_STATUS, 16'h0000);
        chk_rd(ADDR_IRQ_EN, 16'h0000);
        chk_rd(ADDR_RESULT, 16'h0000);
        chk_rd(3'h5, 16'h0000);
        reg_wr(ADDR_STATUS, 16'h0003);
        chk_rd(ADDR_STATUS, 16'h0000);
        // Unqualified commands must not start anything
        @(posedge mclk_i);
        ce   <= 1'b1;
        cs_n <= 1'b1;
        rc   <= 1'b0;
        settle(10);
        chk("busy no select", 16'h0, 16'(busy));
        @(posedge mclk_i);
        rc <= 1'b1;
        settle(5);
        chk("oe_n no select", 16'h7, {13'h0, up_oe_n, mid_oe_n, low_oe_n});
        @(posedge mclk_i);
        ce   <= 1'b0;
        cs_n <= 1'b0;
        rc   <= 1'b0;
        settle(10);
        chk("busy no enable", 16'h0, 16'(busy));
        @(posedge mclk_i);
        rc <= 1'b1;
        settle(4);
        for (int i = 0; i < 8; i++)
        begin
            convert(i[0], i >= 6, i == 0, vins[i]);
            res = exp_q.pop_front();
            rd_pins(1'b1, 1'b0, 12'(res));
            rd_pins(1'b0, 1'b0, 12'(res));
            rd_pins(1'b0, 1'b1, 12'(res));
        end
        finish_test();
    end
endmodule
`default_nettype wire
